// file: rtl/duaic_cfg.svh
`ifndef DUAIC_CFG_SVH
`define DUAIC_CFG_SVH
// Byte addresses: word index times four
`define DUAIC_IDX_MASKED 4'h2
`define DUAIC_IDX_STATUS 4'h5
`define DUAIC_IDX_VECTOR 4'hc
`define DUAIC_IDX_OPSET 4'he
`define DUAIC_IDX_CHANGE 4'h4
`define DUAIC_IDX_CMD_A 4'h2
`define DUAIC_IDX_CMD_B 4'ha
`define DUAIC_IDX_AUX 4'h4
`define DUAIC_IDX_MODE 4'hf
`define DUAIC_CMD_STANDBY_OR_IUS 4'hc
`define DUAIC_CMD_ACTIVE_OR_ZMODE 4'hd
`define DUAIC_CMD_RST_BREAK 4'h5
`define DUAIC_VECTOR_RESET 8'h0f
`define DUAIC_BIT_INCHG 7
`define DUAIC_BIT_BRK_B 6
`define DUAIC_BIT_BRK_A 2
`endif

// file: rtl/duaic_pkg.sv
package duaic_pkg;
    typedef enum logic [1:0] {
        DUAIC_ST_ACTIVE = 2'b00,
        DUAIC_ST_STANDBY = 2'b01
    } duaic_power_t;
endpackage : duaic_pkg

// file: rtl/duaic_top.sv
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`include "duaic_cfg.svh"
// How it works
// - Channel A command 1100 enters standby; power-down output goes high.
// - Standby ends only by reset or the set-active command.
// - Channel A command 1101 returns device to normal operation.
// - Channel B 1100 in vectored mode clears in-service latch; daisy output high.
// - Channel B command 1101 switches into vectored interrupt mode.
// - Read of index 0E pulses counter start, returns zero data.
// - Write of index 0E sets output-port bits where data is one.
// - Output pins present inverted output-port bits.
// - Active-low interrupt request output for all eight conditions.
// - Status register holds eight condition flags in fixed order; only bits 6 and 7 are sticky.
// - Status bit 7 sets on level change of enabled input pins 0-3.
// - Reading the input change report clears status bit 7.
// - Change report gives changed pins and present levels.
// - Status bit 6 sets on channel B break start or end.
// - Status bit 6 clears only by channel B reset-break-change command.
// - Masked status reads as status AND mask.
// - Mask bit one enables its condition; mask is write-only.
// - Vector register is plain read/write byte outside vectored mode.
module duaic_top
    import duaic_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic tx_ready_ch_a_i,
    input wire logic rx_ready_or_full_ch_a_i,
    input wire logic tx_ready_ch_b_i,
    input wire logic rx_ready_or_full_ch_b_i,
    input wire logic counter_ready_i,
    input wire logic break_change_a_i,
    input wire logic received_break_b_i,
    input wire logic [3:0] input_pin_i,
    input wire logic in_service_set_i,
    output logic irq_request_n_o,
    output logic daisy_enable_out_o,
    output logic standby_o,
    output logic vectored_mode_o,
    output logic counter_start_o,
    output logic [7:0] output_pin_o
);
    logic [7:0] status_q, status_d;
    logic [7:0] mask_q;
    logic [7:0] vector_q;
    logic [7:0] out_port_bits_q;
    logic [3:0] aux_control_q;
    logic [3:0] pin_q, delta_q, delta_d;
    logic rb_b_q;
    logic in_service_q;
    duaic_power_t power_q;
    logic zmode_q;
    logic [31:0] rdata_q;
    logic start_q;
    logic ready_q;
    logic slverr_q;

    function automatic logic hit(input logic [7:0] a, input logic [3:0] idx);
        hit = (a[7:6] == 2'b00) && (a[5:2] == idx) && (a[1:0] == 2'b00);
    endfunction : hit

    wire acc = psel_i && penable_i && !ready_q;
    wire wr = acc && pwrite_i;
    wire rd = acc && !pwrite_i;
    wire [3:0] cmd = pwdata_i[7:4];
    wire wr_cmd_a = wr && hit(paddr_i, `DUAIC_IDX_CMD_A);
    wire wr_cmd_b = wr && hit(paddr_i, `DUAIC_IDX_CMD_B);
    wire rd_change = rd && hit(paddr_i, `DUAIC_IDX_CHANGE);
    wire [7:0] masked = status_q & mask_q;
    wire [3:0] pin_diff = input_pin_i ^ pin_q;
    wire pin_event = |(pin_diff & aux_control_q);
    wire brk_b_event = received_break_b_i ^ rb_b_q;
    wire clr_brk_b = wr_cmd_b && (cmd == `DUAIC_CMD_RST_BREAK);
    wire sel_masked = hit(paddr_i, `DUAIC_IDX_MASKED);
    wire sel_status = hit(paddr_i, `DUAIC_IDX_STATUS);
    wire sel_vector = hit(paddr_i, `DUAIC_IDX_VECTOR);
    wire sel_opset = hit(paddr_i, `DUAIC_IDX_OPSET);
    wire sel_change = hit(paddr_i, `DUAIC_IDX_CHANGE);
    wire sel_cmd_a = hit(paddr_i, `DUAIC_IDX_CMD_A);
    wire sel_cmd_b = hit(paddr_i, `DUAIC_IDX_CMD_B);
    wire sel_mode = hit(paddr_i, `DUAIC_IDX_MODE);
    wire mapped = sel_masked || sel_status || sel_vector || sel_opset || sel_change
        || sel_cmd_a || sel_cmd_b || sel_mode;
    wire wr_mask = wr && sel_status;
    wire wr_vector = wr && sel_vector;
    wire wr_opset = wr && sel_opset;
    wire wr_mode = wr && sel_mode;
    wire rd_opset = rd && sel_opset;
    wire set_zmode = wr_cmd_b && (cmd == `DUAIC_CMD_ACTIVE_OR_ZMODE);
    wire clr_in_service = wr_cmd_b && (cmd == `DUAIC_CMD_STANDBY_OR_IUS) && zmode_q;

    // Level-type sources follow their inputs; sticky bits let a set beat a clear
    always_comb begin
        status_d = status_q;
        status_d[0] = tx_ready_ch_a_i;
        status_d[1] = rx_ready_or_full_ch_a_i;
        status_d[3] = counter_ready_i;
        status_d[4] = tx_ready_ch_b_i;
        status_d[5] = rx_ready_or_full_ch_b_i;
        status_d[`DUAIC_BIT_BRK_A] = break_change_a_i;
        if (rd_change) begin
            status_d[`DUAIC_BIT_INCHG] = 1'b0;
        end
        if (pin_event) begin
            status_d[`DUAIC_BIT_INCHG] = 1'b1;
        end
        if (clr_brk_b) begin
            status_d[`DUAIC_BIT_BRK_B] = 1'b0;
        end
        if (brk_b_event) begin
            status_d[`DUAIC_BIT_BRK_B] = 1'b1;
        end
    end

    // Report deltas accumulate until read; a new change in the read cycle survives
    always_comb begin
        delta_d = delta_q | pin_diff;
        if (rd_change) begin
            delta_d = pin_diff;
        end
    end

    wire [31:0] rdata_d =
        sel_status ? {24'h0000_00, status_q} :
        sel_masked ? {24'h0000_00, masked} :
        sel_vector ? {24'h0000_00, vector_q} :
        sel_change ? {24'h0000_00, delta_q, input_pin_i} :
        sel_mode ? {30'h0, zmode_q, power_q == DUAIC_ST_STANDBY} :
        32'h0000_0000;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_q <= 8'h00;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            delta_q <= 4'h0;
        end else begin
            delta_q <= delta_d;
        end
    end

    // Pin history starts low; all pins are disabled at reset, so no false change
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_q <= 4'h0;
        end else begin
            pin_q <= input_pin_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rb_b_q <= 1'b0;
        end else begin
            rb_b_q <= received_break_b_i;
        end
    end

    // Bus side: one wait state so every answer comes from a flip-flop
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= acc;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rd ? rdata_d : 32'h0000_0000;
        end
    end

    // Error is registered alongside the data so the output cannot glitch with paddr
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            slverr_q <= 1'b0;
        end else begin
            slverr_q <= acc && !mapped;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            start_q <= 1'b0;
        end else begin
            start_q <= rd_opset;
        end
    end

    // Write-only mask shares its address with the read-only status
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_q <= 8'h00;
        end else if (wr_mask) begin
            mask_q <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            vector_q <= `DUAIC_VECTOR_RESET;
        end else if (wr_vector) begin
            vector_q <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_port_bits_q <= 8'h00;
        end else if (wr_opset) begin
            out_port_bits_q <= out_port_bits_q | pwdata_i[7:0];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aux_control_q <= 4'h0;
        end else if (wr_mode) begin
            aux_control_q <= pwdata_i[11:8];
        end
    end

    // Codes 1110 and 1111 fall through the default arm untouched
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            power_q <= DUAIC_ST_ACTIVE;
        end else if (wr_cmd_a) begin
            case (cmd)
                `DUAIC_CMD_STANDBY_OR_IUS: power_q <= DUAIC_ST_STANDBY;
                `DUAIC_CMD_ACTIVE_OR_ZMODE: power_q <= DUAIC_ST_ACTIVE;
                default: power_q <= power_q;
            endcase
        end
    end

    // Vectored mode has no leaving command; only reset ends it
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            zmode_q <= 1'b0;
        end else if (set_zmode) begin
            zmode_q <= 1'b1;
        end
    end

    // A set in the same cycle as a clear wins, so no acknowledge is lost
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            in_service_q <= 1'b0;
        end else if (in_service_set_i && zmode_q) begin
            in_service_q <= 1'b1;
        end else if (clr_in_service) begin
            in_service_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_request_n_o <= 1'b1;
        end else begin
            irq_request_n_o <= ~|(status_d & mask_q);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            daisy_enable_out_o <= 1'b1;
        end else begin
            daisy_enable_out_o <= ~in_service_q;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            standby_o <= 1'b0;
        end else begin
            standby_o <= (power_q == DUAIC_ST_STANDBY);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            vectored_mode_o <= 1'b0;
        end else begin
            vectored_mode_o <= zmode_q;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            output_pin_o <= 8'hff;
        end else begin
            output_pin_o <= ~out_port_bits_q;
        end
    end

    assign prdata_o = rdata_q;
    assign pready_o = ready_q;
    assign pslverr_o = slverr_q;
    assign counter_start_o = start_q;
endmodule : duaic_top

// file: bench/duaic_checker.sv
`timescale 1ns/10ps
module duaic_checker (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic standby_o,
    input wire logic vectored_mode_o,
    input wire logic counter_start_o,
    input wire logic [7:0] output_pin_o
);
    // First access cycle: the design acts at its closing edge
    wire logic acc = psel_i && penable_i && !pready_o;
    wire logic wa = acc && pwrite_i && paddr_i == 8'h08;
    wire logic op = acc && paddr_i == 8'h38;
    wire logic [3:0] cd = pwdata_i[7:4];
    wire logic [7:0] wd = pwdata_i[7:0];
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);
    AST_STBY_ON: assert property (wa && cd == 4'hc |-> ##2 standby_o)
        else $error("standby not entered");
    AST_STBY_HOLD: assert property (standby_o && !(wa && cd == 4'hd)
        && !$past(wa && cd == 4'hd) |=> standby_o) else $error("standby left");
    AST_ACTIVE: assert property (wa && cd == 4'hd |-> ##2 !standby_o)
        else $error("standby kept");
    AST_ZMODE: assert property (acc && pwrite_i && paddr_i == 8'h28 && cd == 4'hd
        |-> ##2 vectored_mode_o) else $error("vectored mode not set");
    AST_CNT_START: assert property (op && !pwrite_i |=> counter_start_o)
        else $error("counter start missing");
    AST_OPSET: assert property (op && pwrite_i
        |-> ##2 output_pin_o == ($past(output_pin_o) & ~$past(wd, 2)))
        else $error("pins wrong");
    AST_OP_HOLD: assert property (!(op && pwrite_i) |-> ##2 $stable(output_pin_o))
        else $error("pins moved");
    AST_RSVD: assert property (wa && cd[3:1] == 3'b111 |-> ##2 $stable(standby_o))
        else $error("reserved code acted");
endmodule : duaic_checker
bind duaic_top duaic_checker duaic_checker_i (.mclk_i, .rst_b_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .standby_o, .vectored_mode_o,
    .counter_start_o, .output_pin_o);

// file: bench/duaic_host.sv
`timescale 1ns/10ps
module duaic_host (
    input wire logic mclk_i,
    input wire logic pready_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o
);
    initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} <= {2'b10, w, a, d};
        @(posedge mclk_i);
        penable_o <= 1'b1;
        do @(posedge mclk_i); while (!pready_i);
        // Released lines carry garbage so a stale value cannot pass
        {psel_o, penable_o, paddr_o, pwdata_o} <= {2'b00, ~a, ~d};
    endtask : xfer
endmodule : duaic_host

// file: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic mclk_i = 1'b0, rst_b_i = 1'b0, received_break_b_i = 1'b0, in_service_set_i = 1'b0;
    logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, irq_request_n_o, daisy_enable_out_o;
    logic [7:0] paddr_i, output_pin_o, v, m;
    logic [31:0] pwdata_i, prdata_o;
    logic [5:0] lv = '0;
    logic [3:0] input_pin_i = '0;
    logic [3:0] codes[4] = '{4'hc, 4'he, 4'hf, 4'hd};
    logic [32:0] q[$];
    int num_errors = 0, n_compared = 0;
    always #25 mclk_i = ~mclk_i;
    duaic_host host_i (.mclk_i, .pready_i(pready_o), .psel_o(psel_i), .penable_o(penable_i),
        .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));
    duaic_top duaic_top_i (.mclk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .tx_ready_ch_a_i(lv[0]),
        .rx_ready_or_full_ch_a_i(lv[1]), .break_change_a_i(lv[2]), .counter_ready_i(lv[3]),
        .tx_ready_ch_b_i(lv[4]), .rx_ready_or_full_ch_b_i(lv[5]), .received_break_b_i,
        .input_pin_i, .in_service_set_i, .irq_request_n_o, .daisy_enable_out_o,
        .standby_o(), .vectored_mode_o(), .counter_start_o(), .output_pin_o);
    task give_verdict;
        if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    task chk(input string nm, input logic [32:0] s, e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task rd(input logic [7:0] a, e, input logic er = 1'b0);
        q.push_back({er, 24'h0, e});
        host_i.xfer(1'b0, a, 32'h0);
    endtask : rd
    task wr(input logic [7:0] a, input logic [31:0] d);
        host_i.xfer(1'b1, a, d);
    endtask : wr
    always @(posedge mclk_i) if (psel_i && penable_i && pready_o && !pwrite_i)
        chk("rdata", {pslverr_o, prdata_o}, q.pop_front());
    initial begin
        repeat (4000) @(posedge mclk_i);
        num_errors++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h5a30));
        repeat (2) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        rd(8'h30, 8'h0f);
        lv <= 6'($urandom);
        m = $urandom;
        wr(8'h14, {24'h0, m});
        rd(8'h14, {2'b00, lv});
        rd(8'h08, {2'b00, lv} & m);
        chk("irq", irq_request_n_o, ({2'b00, lv} & m) == 8'h00);
        received_break_b_i <= 1'b1;
        wr(8'h08, 32'h50);
        rd(8'h14, {2'b01, lv});
        wr(8'h28, 32'h50);
        rd(8'h14, {2'b00, lv});
        wr(8'h3c, 32'h100);
        wr(8'h14, 32'h80);
        input_pin_i <= 4'h1;
        rd(8'h14, {2'b10, lv});
        chk("irq", irq_request_n_o, 1'b0);
        rd(8'h10, 8'h11);
        rd(8'h14, {2'b00, lv});
        chk("irq", irq_request_n_o, 1'b1);
        v = $urandom;
        wr(8'h38, {24'h0, v});
        wr(8'h38, 32'h1);
        rd(8'h38, 8'h00);
        chk("pins", output_pin_o, 8'(~(v | 8'h01)));
        foreach (codes[i]) begin
            wr(8'h08, {24'h0, codes[i], 4'h0});
            rd(8'h3c, {7'h0, i != 3});
        end
        wr(8'h28, 32'hd0);
        rd(8'h3c, 8'h02);
        in_service_set_i <= 1'b1;
        @(posedge mclk_i) in_service_set_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk("daisy", daisy_enable_out_o, 1'b0);
        wr(8'h28, 32'hc0);
        rd(8'h04, 8'h00, 1'b1);
        chk("daisy", daisy_enable_out_o, 1'b1);
        give_verdict();
    end
endmodule : testbench
